// File: design/jfb_bridge.sv
/*
 jfb_bridge: jtag to serial flash bridge with io reload and restart.
 assumes tck, tms, tdi, config pins are asynchronous to clock;
 tck must be slower than clock/4 (bench uses 400 ns).
*/
`timescale 1ns/1ns
module jfb_bridge #(
   parameter int GUARD_CYCLES = jfb_pkg::GUARD_CYCLES
) (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic tck,
   input  wire logic tms,
   input  wire logic tdi,
   output logic      tdo,
   output logic      tdo_oe,
   input  wire logic config_finished_in,
   input  wire logic restart_n,
   input  wire logic chain_enable_n,
   output logic      serial_clock_out,
   output logic      select_out_n,
   output logic      flash_command_out,
   input  wire logic flash_command_in,
   output logic      user_mode,
   output logic      user_io_oe,
   output logic      io_chain_reload,
   output logic      reconfig_req,
   output logic      bridge_busy
);
   typedef enum logic [3:0] {
      T_RESET = 4'h0, T_IDLE = 4'h1, T_SEL_DR = 4'h2, T_CAP_DR = 4'h3,
      T_SH_DR = 4'h4, T_EX1_DR = 4'h5, T_PA_DR = 4'h6, T_EX2_DR = 4'h7,
      T_UP_DR = 4'h8, T_SEL_IR = 4'h9, T_CAP_IR = 4'hA, T_SH_IR = 4'hB,
      T_EX1_IR = 4'hC, T_PA_IR = 4'hD, T_EX2_IR = 4'hE, T_UP_IR = 4'hF
   } jfb_tap_type;

   function automatic jfb_tap_type tap_step(input jfb_tap_type s, input logic m);
      unique case (s)
         T_RESET:  tap_step = m ? T_RESET : T_IDLE;
         T_IDLE:   tap_step = m ? T_SEL_DR : T_IDLE;
         T_SEL_DR: tap_step = m ? T_SEL_IR : T_CAP_DR;
         T_CAP_DR: tap_step = m ? T_EX1_DR : T_SH_DR;
         T_SH_DR:  tap_step = m ? T_EX1_DR : T_SH_DR;
         T_EX1_DR: tap_step = m ? T_UP_DR : T_PA_DR;
         T_PA_DR:  tap_step = m ? T_EX2_DR : T_PA_DR;
         T_EX2_DR: tap_step = m ? T_UP_DR : T_SH_DR;
         T_UP_DR:  tap_step = m ? T_SEL_DR : T_IDLE;
         T_SEL_IR: tap_step = m ? T_RESET : T_CAP_IR;
         T_CAP_IR: tap_step = m ? T_EX1_IR : T_SH_IR;
         T_SH_IR:  tap_step = m ? T_EX1_IR : T_SH_IR;
         T_EX1_IR: tap_step = m ? T_UP_IR : T_PA_IR;
         T_PA_IR:  tap_step = m ? T_EX2_IR : T_PA_IR;
         T_EX2_IR: tap_step = m ? T_UP_IR : T_SH_IR;
         T_UP_IR:  tap_step = m ? T_SEL_DR : T_IDLE;
      endcase
   endfunction

   // no chain enable output here: that pin stays free for user io
   // two-stage synchronisers; first stage read only by second
   logic [5:0] sync1, sync2;
   logic       tck_d;
   always_ff @(posedge clock) begin
      if (rst) begin
         // tck idles low; a matching reset value avoids a false edge
         sync1 <= 6'h0F;
         sync2 <= 6'h0F;
         tck_d <= 1'b0;
      end else begin
         sync1 <= {flash_command_in, tck, tms, tdi, restart_n, config_finished_in};
         sync2 <= sync1;
         tck_d <= sync2[4];
      end
   end
   logic s_tms, s_tdi, s_restart_n, tck_rise, tck_fall, s_flash_in;
   // returned flash bits lag one flash clock through the synchroniser
   assign s_flash_in  = sync2[5];
   assign s_tms       = sync2[3];
   assign s_tdi       = sync2[2];
   assign s_restart_n = sync2[1];
   assign tck_rise    = sync2[4] && !tck_d;
   assign tck_fall    = !sync2[4] && tck_d;

   localparam int DW = jfb_pkg::DATA_WIDTH;
   localparam int IW = jfb_pkg::IR_WIDTH;
   localparam int GW = $clog2(GUARD_CYCLES + 1);

   jfb_tap_type      tap, next_tap;
   logic [IW-1:0]    ir_sh, next_ir_sh, ir, next_ir;
   logic [DW-1:0]    dr_sh, next_dr_sh;
   logic [$clog2(DW)-1:0] bit_cnt, next_bit_cnt;
   logic             tdo_q, next_tdo_q, tdo_oe_q, next_tdo_oe_q;
   logic             io_reload, next_io_reload;
   logic             restart, next_restart;
   logic             in_valid, next_in_valid;
   logic [DW-1:0]    in_data, next_in_data;
   logic             in_ready;
   logic [GW-1:0]    guard, next_guard;
   logic             usr, next_usr;

   always_comb begin
      next_tap      = tap;
      next_ir_sh    = ir_sh;
      next_ir       = ir;
      next_dr_sh    = dr_sh;
      next_bit_cnt  = bit_cnt;
      next_tdo_q    = tdo_q;
      next_tdo_oe_q = tdo_oe_q;
      next_io_reload = io_reload;
      next_restart  = 1'b0;
      next_in_valid = in_valid && !in_ready;
      next_in_data  = in_data;
      next_guard    = (guard != '0) ? GW'(guard - 1'b1) : guard;
      next_usr      = usr;
      // restart pin low: hold guard, leave io reload
      if (!s_restart_n) begin
         next_guard     = GW'(GUARD_CYCLES);
         next_io_reload = 1'b0;
      end
      if (tck_rise) begin
         next_tap = tap_step(tap, s_tms);
         if (tap == T_SH_IR) begin
            next_ir_sh = {s_tdi, ir_sh[IW-1:1]};
         end
         if (tap == T_SH_DR && ir == jfb_pkg::IR_BRIDGE) begin
            // lsb first bytes go to the flash path
            next_dr_sh   = {s_tdi, dr_sh[DW-1:1]};
            next_bit_cnt = ($clog2(DW))'(bit_cnt + 1'b1);
            if (bit_cnt == ($clog2(DW))'(DW - 1)) begin
               next_in_valid = 1'b1;
               next_in_data  = {s_tdi, dr_sh[DW-1:1]};
            end
         end
         if (tap == T_CAP_DR) begin
            next_bit_cnt = '0;
            next_dr_sh   = {DW{1'b0}};
            next_dr_sh[0] = in_ready;
         end
         if (tap == T_CAP_IR) begin
            next_ir_sh = {{(IW-1){1'b0}}, 1'b1};
         end
         if (tap == T_UP_IR) begin
            next_ir = ir_sh;
            // io reload only in user mode and after guard
            if (ir_sh == jfb_pkg::IR_IORELOAD && usr && guard == '0) begin
               next_io_reload = 1'b1;
            end
            if (ir_sh == jfb_pkg::IR_RESTART) begin
               next_restart   = 1'b1;
               next_io_reload = 1'b0;
               next_guard     = GW'(GUARD_CYCLES);
            end
         end
         if (tap_step(tap, s_tms) == T_RESET) begin
            next_ir = jfb_pkg::IR_BYPASS;
         end
      end
      if (tck_fall) begin
         next_tdo_oe_q = (tap == T_SH_DR) || (tap == T_SH_IR);
         next_tdo_q    = (tap == T_SH_IR) ? ir_sh[0] : dr_sh[0];
      end
      // user mode ignores config_finished held low by slaves
      if (guard == '0 && s_restart_n) begin
         next_usr = 1'b1;
      end
      if (restart || !s_restart_n) begin
         next_usr = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tap       <= T_RESET;
         ir_sh     <= '0;
         ir        <= jfb_pkg::IR_BYPASS;
         dr_sh     <= '0;
         bit_cnt   <= '0;
         tdo_q     <= 1'b0;
         tdo_oe_q  <= 1'b0;
         io_reload <= 1'b0;
         restart   <= 1'b0;
         in_valid  <= 1'b0;
         in_data   <= '0;
         guard     <= GW'(GUARD_CYCLES);
         usr       <= 1'b0;
      end else begin
         tap       <= next_tap;
         ir_sh     <= next_ir_sh;
         ir        <= next_ir;
         dr_sh     <= next_dr_sh;
         bit_cnt   <= next_bit_cnt;
         tdo_q     <= next_tdo_q;
         tdo_oe_q  <= next_tdo_oe_q;
         io_reload <= next_io_reload;
         restart   <= next_restart;
         in_valid  <= next_in_valid;
         in_data   <= next_in_data;
         guard     <= next_guard;
         usr       <= next_usr;
      end
   end

   logic [DW-1:0] f_data;
   logic          f_valid, f_ready;
   jfb_fifo #(.WIDTH(DW), .DEPTH(jfb_pkg::FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_data   (in_data),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_ready)
   );

   // flash shifter: msb first, select low while bytes flow
   logic [DW-1:0] fsh, next_fsh;
   logic [3:0]    fcnt, next_fcnt;
   logic          sclk, next_sclk, sel_n, next_sel_n, fout, next_fout, active;
   assign active  = (ir == jfb_pkg::IR_BRIDGE) && !restart;
   assign f_ready = (fcnt == '0) && !sclk && active;

   always_comb begin
      next_fsh   = fsh;
      next_fcnt  = fcnt;
      next_sclk  = 1'b0;
      // a cut byte finishes before select rises
      next_sel_n = (active || fcnt != '0) ? sel_n : 1'b1;
      next_fout  = fout;
      if (f_ready && f_valid) begin
         next_fsh   = f_data;
         next_fcnt  = 4'(DW);
         next_sel_n = 1'b0;
         next_fout  = f_data[DW-1];
      end else if (fcnt != '0) begin
         // data moves only with the falling flash edge, set up for the rise
         if (!sclk) begin
            next_sclk = 1'b1;
         end else begin
            next_fsh  = {fsh[DW-2:0], s_flash_in};
            next_fcnt = 4'(fcnt - 1'b1);
            next_fout = fsh[DW-2];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         fsh   <= '0;
         fcnt  <= '0;
         sclk  <= 1'b0;
         sel_n <= 1'b1;
         fout  <= 1'b0;
      end else begin
         fsh   <= next_fsh;
         fcnt  <= next_fcnt;
         sclk  <= next_sclk;
         sel_n <= next_sel_n;
         fout  <= next_fout;
      end
   end

   logic busy_q, oe_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         busy_q <= 1'b0;
         oe_q   <= 1'b0;
      end else begin
         busy_q <= f_valid || (fcnt != '0);
         oe_q   <= usr && !next_io_reload;
      end
   end

   assign tdo               = tdo_q;
   assign tdo_oe            = tdo_oe_q;
   assign serial_clock_out  = sclk;
   assign select_out_n      = sel_n;
   assign flash_command_out = fout;
   assign user_mode         = usr;
   assign user_io_oe        = oe_q;
   assign io_chain_reload   = io_reload;
   assign reconfig_req      = restart;
   assign bridge_busy       = busy_q;

   a_restart_clears: assert property (@(posedge clock) disable iff (rst)
      restart |=> !usr) else $error("user mode kept after restart");
   a_reload_tristate: assert property (@(posedge clock) disable iff (rst)
      io_reload |-> !user_io_oe) else $error("io driven in reload");
   a_reload_user: assert property (@(posedge clock) disable iff (rst)
      $rose(io_reload) |-> $past(usr)) else $error("reload outside user");
   a_sel_byte: assert property (@(posedge clock) disable iff (rst)
      (fcnt != '0) |-> !select_out_n) else $error("select high mid byte");
   a_sclk_pulse: assert property (@(posedge clock) disable iff (rst)
      sclk |=> !sclk) else $error("clock high two cycles");
   a_restart_pulse: assert property (@(posedge clock) disable iff (rst)
      restart |=> !restart) else $error("restart not a pulse");
   a_guard_load: assert property (@(posedge clock) disable iff (rst)
      restart |-> guard == GW'(GUARD_CYCLES - 1) || guard == GW'(GUARD_CYCLES))
      else $error("guard not loaded");
   a_user_ignores_done: assert property (@(posedge clock) disable iff (rst)
      (guard == '0 && s_restart_n && !restart) |=> usr)
      else $error("user mode blocked");
   a_reload_guard: assert property (@(posedge clock) disable iff (rst)
      $rose(io_reload) |-> $past(guard) == '0) else $error("reload inside guard");
   a_data_setup: assert property (@(posedge clock) disable iff (rst)
      sclk |-> $stable(flash_command_out)) else $error("data moved at rise");
   a_sclk_framed: assert property (@(posedge clock) disable iff (rst)
      serial_clock_out |-> !select_out_n) else $error("clock while deselected");
endmodule

// File: design/jfb_fifo.sv
/*
 jfb_fifo: valid/ready fifo, width and depth parameters.
 assumes a single clock and synchronous active high reset.
*/
`timescale 1ns/1ns
module jfb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             do_wr, do_rd;

   always_comb begin
      do_wr       = in_valid && in_ready;
      do_rd       = out_valid && out_ready;
      next_wr_ptr = do_wr ? AW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = do_rd ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_count  = count;
      if (do_wr && !do_rd) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (do_rd && !do_wr) begin
         next_count = (AW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge clock) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
endmodule

// File: design/jfb_pkg.sv
/*
 jfb_pkg: constants for the jtag flash bridge.
 assumes a 20 MHz system clock; jtag pins arrive asynchronous.
*/
// Functional notes
// - bridge owns clock, data in, command out and select of the flash.
// - jtag shifted data is forwarded to the flash pins.
// - user mode is reached even with config_finished held low.
// - no self reconfiguration; host issues restart pulse instruction.
// - restart pulse resets and discards the bridge logic; here it only clears user mode and io reload and reloads the guard.
// - io reload instruction reloads the io setting shift chain.
// - io reload accepted any time in user mode.
// - select pin acts as select_out_n, data 1 as flash_command_out.
// - chain enable output may be left unused.
// - during io reload all user io are high impedance.
package jfb_pkg;
   localparam int CLK_HZ        = 20000000;
   localparam int GUARD_MS      = 230;
   localparam int GUARD_CYCLES  = (CLK_HZ / 1000) * GUARD_MS;
   localparam int IR_WIDTH      = 4;
   localparam logic [3:0] IR_BRIDGE   = 4'h1;
   localparam logic [3:0] IR_IORELOAD = 4'h2;
   localparam logic [3:0] IR_RESTART  = 4'h3;
   localparam logic [3:0] IR_BYPASS   = 4'hF;
   localparam int DATA_WIDTH    = 8;
   localparam int FIFO_DEPTH    = 16;
   localparam int SCLK_DIV      = 2;
endpackage

// File: verif/jfb_flash_model.sv
/*
 jfb_flash_model: behavioural serial flash on the far side of the bridge.
 assumes flash clock pulses only while select_out_n is low.
*/
`timescale 1ns/1ns
module jfb_flash_model (
   input  wire logic   serial_clock_out,
   input  wire logic   select_out_n,
   input  wire logic   flash_command_out,
   output logic        flash_command_in,
   output logic [15:0] rx_word,
   output int          rx_bits
);
   logic last;
   initial begin
      rx_word = 16'h0000;
      rx_bits = 0;
      last    = 1'b0;
   end
   // msb first capture on the flash clock, only while selected
   always @(posedge serial_clock_out) begin
      if (!select_out_n) begin
         rx_word <= {rx_word[14:0], flash_command_out};
         rx_bits <= rx_bits + 1;
         last    <= ~last;
      end
   end
   // released line shows the inverse, so a stale level never passes
   assign flash_command_in = select_out_n ? ~last : last;
endmodule

// File: verif/testbench.sv
/*
 testbench: jtag host tasks driving the bridge, flash model on the far side.
 assumes tck at 400 ns standing low between scans, guard shortened.
*/
`timescale 1ns/1ns
module testbench;
   localparam int GUARD = 200;
   logic        clock, rst, tck, tms, tdi, restart_n, cmd_in;
   logic        tdo, tdo_oe, sclk, sel_n, cmd_out, user_mode, io_oe, io_reload, reconfig_req;
   logic        busy;
   logic [15:0] rx_word;
   int          rx_bits, pulses, cycles, miscompares, num_checks;

   // lone master device, strapped for the active serial scheme
   jfb_bridge #(.GUARD_CYCLES(GUARD)) u_dut (
      .clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .config_finished_in(1'b0),
      .restart_n(restart_n),
      .chain_enable_n(1'b0),
      .serial_clock_out(sclk), .select_out_n(sel_n), .flash_command_out(cmd_out),
      .flash_command_in(cmd_in), .user_mode(user_mode), .user_io_oe(io_oe),
      .io_chain_reload(io_reload), .reconfig_req(reconfig_req), .bridge_busy(busy));

   jfb_flash_model u_flash (
      .serial_clock_out(sclk), .select_out_n(sel_n), .flash_command_out(cmd_out),
      .flash_command_in(cmd_in), .rx_word(rx_word), .rx_bits(rx_bits));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic report_and_stop;
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one tck period; tms and tdi change while tck is low
   task automatic jbit(input logic m, input logic d);
      @(posedge clock);
      #2;
      tms = m;
      tdi = d;
      repeat (3) @(posedge clock);
      #2 tck = 1'b1;
      repeat (4) @(posedge clock);
      #2 tck = 1'b0;
   endtask

   task automatic shift_ir(input logic [3:0] code);
      jbit(1'b1, 1'b0);
      jbit(1'b1, 1'b0);
      jbit(1'b0, 1'b0);
      jbit(1'b0, 1'b0);
      for (int i = 0; i < 4; i++) jbit(i == 3, code[i]);
      jbit(1'b1, 1'b0);
      jbit(1'b0, 1'b0);
      repeat (6) @(posedge clock);
      #2;
   endtask

   task automatic shift_dr16(input logic [15:0] w);
      jbit(1'b1, 1'b0);
      jbit(1'b0, 1'b0);
      jbit(1'b0, 1'b0);
      // capture put fifo ready in bit 0; it shows while shifting
      repeat (4) @(posedge clock);
      #2;
      check("tdo capture", {14'h0000, tdo_oe, tdo}, 16'h0003);
      for (int i = 0; i < 16; i++) jbit(i == 15, w[i]);
      jbit(1'b1, 1'b0);
      jbit(1'b0, 1'b0);
   endtask

   always @(posedge clock) begin
      if (!rst && reconfig_req === 1'b1) pulses++;
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end

   initial begin
      rst = 1'b1;
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      restart_n = 1'b1;
      pulses = 0;
      cycles = 0;
      miscompares = 0;
      num_checks = 0;
      repeat (20) @(posedge clock);
      #2 rst = 1'b0;
      @(posedge clock);
      #2;
      check("select_out_n", {15'h0000, sel_n}, 16'h0001);
      check("user_mode rst", {15'h0000, user_mode}, 16'h0000);
      // host waits out the power up guard before any reload
      repeat (GUARD + 10) @(posedge clock);
      #2;
      check("user_mode", {15'h0000, user_mode}, 16'h0001);
      check("user io drive", {15'h0000, io_oe}, 16'h0001);
      for (int i = 0; i < 5; i++) jbit(1'b1, 1'b0);
      jbit(1'b0, 1'b0);
      shift_ir(jfb_pkg::IR_BRIDGE);
      // two bytes back to back in one scan, lsb first on the wire
      shift_dr16(16'h3CA5);
      for (int i = 0; i < 400 && rx_bits < 16; i++) @(posedge clock);
      repeat (40) @(posedge clock);
      #2;
      check("flash bytes", rx_word, 16'hA53C);
      check("bit count", rx_bits[15:0], 16'h0010);
      check("busy", {15'h0000, busy}, 16'h0000);
      check("no self restart", pulses[15:0], 16'h0000);
      shift_ir(jfb_pkg::IR_IORELOAD);
      check("io reload", {15'h0000, io_reload}, 16'h0001);
      check("user io tristate", {15'h0000, io_oe}, 16'h0000);
      check("select released", {15'h0000, sel_n}, 16'h0001);
      // testing over: the host reconfigures by the restart pulse
      shift_ir(jfb_pkg::IR_RESTART);
      check("restart pulse", pulses[15:0], 16'h0001);
      check("reload ends", {15'h0000, io_reload}, 16'h0000);
      repeat (GUARD + 10) @(posedge clock);
      // restart pin low across a whole scan: the reload must be ignored
      #2 restart_n = 1'b0;
      shift_ir(jfb_pkg::IR_IORELOAD);
      check("reload pin low", {15'h0000, io_reload}, 16'h0000);
      restart_n = 1'b1;
      shift_ir(jfb_pkg::IR_IORELOAD);
      check("reload in guard", {15'h0000, io_reload}, 16'h0000);
      repeat (GUARD + 10) @(posedge clock);
      shift_ir(jfb_pkg::IR_IORELOAD);
      check("reload after guard", {15'h0000, io_reload}, 16'h0001);
      // reset in mid run drops user mode and the reload
      rst = 1'b1;
      repeat (2) @(posedge clock);
      #2 rst = 1'b0;
      @(posedge clock);
      #2;
      check("reload after rst", {15'h0000, io_reload}, 16'h0000);
      check("user_mode after rst", {15'h0000, user_mode}, 16'h0000);
      report_and_stop();
   end
endmodule
